// [logic/ltpr_top.v]
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "ltpr_regs.vh"
module ltpr_top (
   input wire clk,
   input wire arst_n,
   input wire [8:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire [`LTPR_NWIRE-1:0] route_in,
   output reg [`LTPR_NWIRE-1:0] route_out,
   input wire [7:0] dp_cond,
   input wire [1:0] dp_shift_out,
   output reg [2:0] dp_cfg_addr,
   output reg [2:0] dp_shift_in,
   output reg [3:0] clk_en,
   output reg [7:0] clk_sel,
   output reg [7:0] irq_req,
   output reg [7:0] dma_req,
   input wire [7:0] pin_in,
   output reg [7:0] pin_out,
   output reg [7:0] pin_oe
);
   // Software-visible registers
   reg [7:0] ctrl_q;
   reg [7:0] stat_q;
   reg [7:0] stcap_q;
   reg [7:0] reqtype_q;
   reg [7:0] osync_q;
   reg [7:0] isync_q;
   reg [1:0] oemode_q;
   reg [7:0] cken_q;
   reg [11:0] ckbit_q;
   reg [7:0] cksel_q;
   reg [23:0] dposrc_q;
   reg [`LTPR_NWIRE-1:0] seg_q;
   reg [`LTPR_SEL_W-1:0] sel_q [0:`LTPR_NSEL-1];

   // Internal pipeline state
   reg [5:0] dpo_q;
   reg [7:0] pout_pipe_q;
   reg [7:0] oe_pipe_q;

   // Combinational nets
   reg [`LTPR_NWIRE-1:0] local_d;
   reg [7:0] stat_raw;
   reg [5:0] dp_in;
   reg [7:0] req_raw;
   reg [7:0] pout_raw;
   reg [3:0] oe_raw;
   reg [7:0] oe_pin;
   reg [5:0] dpo_d;
   reg [3:0] clk_en_d;
   reg [7:0] stat_d;
   reg [31:0] rdata_d;
   wire [`LTPR_NWIRE-1:0] wire_v;
   wire [7:0] pin_sync;
   wire [7:0] pin_rt;
   wire stat_rd;
   wire sel_hit;
   wire [5:0] sel_idx;
   // Loop indices, one per process so no process wakes another
   integer i_drv;
   integer i_tap;
   integer i_dpo;
   integer i_ckn;
   integer i_rst;

   // One-hot drive mask for a wire selector
   function [`LTPR_NWIRE-1:0] wire_mask;
      input [`LTPR_SEL_W-1:0] idx;
      reg [`LTPR_NWIRE-1:0] m;
      begin
         m = {`LTPR_NWIRE{1'b0}};
         if (idx < `LTPR_NWIRE) begin
            m[idx] = 1'b1;
         end
         wire_mask = m;
      end
   endfunction

   // Level of a selected wire, zero when unconnected
   function wire_pick;
      input [`LTPR_NWIRE-1:0] v;
      input [`LTPR_SEL_W-1:0] idx;
      begin
         if (idx < `LTPR_NWIRE) begin
            wire_pick = v[idx];
         end else begin
            wire_pick = 1'b0;
         end
      end
   endfunction

   // Pin inputs resynchronised on the system clock
   ltpr_sync #(
      .W(8)
   ) u_pin_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d(pin_in),
      .q(pin_sync)
   );

   // Per-pin choice of synchronised or raw feed-through
   assign pin_rt = (isync_q & pin_sync) | (~isync_q & pin_in);

   // Local drivers onto the routing wires
   always @* begin
      local_d = {`LTPR_NWIRE{1'b0}};
      for (i_drv = 0; i_drv < 8; i_drv = i_drv + 1) begin
         if (ctrl_q[i_drv]) begin
            local_d = local_d | wire_mask(sel_q[`LTPR_SI_CTRL + i_drv]);
         end
         if (pin_rt[i_drv]) begin
            local_d = local_d | wire_mask(sel_q[`LTPR_SI_PININ + i_drv]);
         end
      end
      for (i_drv = 0; i_drv < 6; i_drv = i_drv + 1) begin
         if (dpo_q[i_drv]) begin
            local_d = local_d | wire_mask(sel_q[`LTPR_SI_DPOUT + i_drv]);
         end
      end
   end

   // Segmented wires ignore the far part of the channel
   assign wire_v = local_d | (route_in & ~seg_q);

   // Taps off the routing wires
   always @* begin
      stat_raw = 8'h00;
      req_raw = 8'h00;
      pout_raw = 8'h00;
      dp_in = 6'h00;
      oe_raw = 4'h0;
      for (i_tap = 0; i_tap < 8; i_tap = i_tap + 1) begin
         stat_raw[i_tap] = wire_pick(wire_v, sel_q[`LTPR_SI_STAT + i_tap]);
         req_raw[i_tap] = wire_pick(wire_v, sel_q[`LTPR_SI_REQ + i_tap]);
         pout_raw[i_tap] = wire_pick(wire_v, sel_q[`LTPR_SI_PINOUT + i_tap]);
      end
      for (i_tap = 0; i_tap < 6; i_tap = i_tap + 1) begin
         dp_in[i_tap] = wire_pick(wire_v, sel_q[`LTPR_SI_DPIN + i_tap]);
      end
      for (i_tap = 0; i_tap < 4; i_tap = i_tap + 1) begin
         oe_raw[i_tap] = wire_pick(wire_v, sel_q[`LTPR_SI_OE + i_tap]);
      end
   end

   // Datapath output source selection
   always @* begin
      dpo_d = 6'h00;
      for (i_dpo = 0; i_dpo < 6; i_dpo = i_dpo + 1) begin
         if (dposrc_q[4*i_dpo+3] == 1'b0) begin
            dpo_d[i_dpo] = dp_cond[dposrc_q[4*i_dpo +: 3]];
         end else if (dposrc_q[4*i_dpo +: 4] == `LTPR_DPO_SO0) begin
            dpo_d[i_dpo] = dp_shift_out[0];
         end else if (dposrc_q[4*i_dpo +: 4] == `LTPR_DPO_SO1) begin
            dpo_d[i_dpo] = dp_shift_out[1];
         end
      end
   end

   // Output enable grouping across the eight pins, single mode enables pins 0..3 only
   always @* begin
      case (oemode_q)
         `LTPR_OE_ALL: oe_pin = {8{oe_raw[0]}};
         `LTPR_OE_QUAD: oe_pin = {{4{oe_raw[1]}}, {4{oe_raw[0]}}};
         `LTPR_OE_PAIR: oe_pin = {{2{oe_raw[3]}}, {2{oe_raw[2]}}, {2{oe_raw[1]}}, {2{oe_raw[0]}}};
         default: oe_pin = {4'h0, oe_raw};
      endcase
   end

   // Clock enable per sub-block, static or from a control bit
   always @* begin
      clk_en_d = 4'h0;
      for (i_ckn = 0; i_ckn < 4; i_ckn = i_ckn + 1) begin
         if (cken_q[4+i_ckn]) begin
            clk_en_d[i_ckn] = ctrl_q[ckbit_q[3*i_ckn +: 3]];
         end else begin
            clk_en_d[i_ckn] = cken_q[i_ckn];
         end
      end
   end

   // Status capture: new events win over the read clear
   assign stat_rd = reg_rd && (reg_addr == `LTPR_A_STATUS);
   always @* begin
      stat_d = (stcap_q & ((stat_q & ~{8{stat_rd}}) | stat_raw)) | (~stcap_q & stat_raw);
   end

   // Selector table decode
   assign sel_idx = reg_addr[7:2];
   assign sel_hit = reg_addr[8] && (reg_addr[1:0] == 2'b00) && (sel_idx < `LTPR_NSEL);

   // Read data mux, unmapped addresses read zero
   always @* begin
      rdata_d = 32'h00000000;
      case (reg_addr)
         `LTPR_A_CTRL: rdata_d = {24'h000000, ctrl_q};
         `LTPR_A_STATUS: rdata_d = {24'h000000, stat_q};
         `LTPR_A_STCAP: rdata_d = {24'h000000, stcap_q};
         `LTPR_A_REQTYPE: rdata_d = {24'h000000, reqtype_q};
         `LTPR_A_OSYNC: rdata_d = {24'h000000, osync_q};
         `LTPR_A_ISYNC: rdata_d = {24'h000000, isync_q};
         `LTPR_A_OEMODE: rdata_d = {30'h0, oemode_q};
         `LTPR_A_CKEN: rdata_d = {24'h000000, cken_q};
         `LTPR_A_CKBIT: rdata_d = {20'h00000, ckbit_q};
         `LTPR_A_CKSEL: rdata_d = {24'h000000, cksel_q};
         `LTPR_A_DPOSRC: rdata_d = {8'h00, dposrc_q};
         `LTPR_A_SEG0: rdata_d = seg_q[31:0];
         `LTPR_A_SEG1: rdata_d = seg_q[63:32];
         `LTPR_A_SEG2: rdata_d = seg_q[95:64];
         default: begin
            if (sel_hit) begin
               rdata_d = {25'h0, sel_q[sel_idx]};
            end
         end
      endcase
   end

   // Register writes
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= 8'h00;
         stcap_q <= 8'h00;
         reqtype_q <= 8'h00;
         osync_q <= 8'h00;
         isync_q <= `LTPR_RST_ISYNC;
         oemode_q <= `LTPR_OE_ALL;
         cken_q <= `LTPR_RST_CKEN;
         ckbit_q <= 12'h000;
         cksel_q <= 8'h00;
         dposrc_q <= 24'h000000;
         seg_q <= {`LTPR_NWIRE{1'b0}};
         for (i_rst = 0; i_rst < `LTPR_NSEL; i_rst = i_rst + 1) begin
            sel_q[i_rst] <= `LTPR_SEL_NONE;
         end
      end else if (reg_wr) begin
         case (reg_addr)
            `LTPR_A_CTRL: ctrl_q <= reg_wdata[7:0];
            `LTPR_A_STCAP: stcap_q <= reg_wdata[7:0];
            `LTPR_A_REQTYPE: reqtype_q <= reg_wdata[7:0];
            `LTPR_A_OSYNC: osync_q <= reg_wdata[7:0];
            `LTPR_A_ISYNC: isync_q <= reg_wdata[7:0];
            `LTPR_A_OEMODE: oemode_q <= reg_wdata[1:0];
            `LTPR_A_CKEN: cken_q <= reg_wdata[7:0];
            `LTPR_A_CKBIT: ckbit_q <= reg_wdata[11:0];
            `LTPR_A_CKSEL: cksel_q <= reg_wdata[7:0];
            `LTPR_A_DPOSRC: dposrc_q <= reg_wdata[23:0];
            `LTPR_A_SEG0: seg_q[31:0] <= reg_wdata;
            `LTPR_A_SEG1: seg_q[63:32] <= reg_wdata;
            `LTPR_A_SEG2: seg_q[95:64] <= reg_wdata;
            default: begin
               if (sel_hit) begin
                  sel_q[sel_idx] <= reg_wdata[6:0];
               end
            end
         endcase
      end
   end

   // Fabric state and outputs, all registered
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stat_q <= 8'h00;
         dpo_q <= 6'h00;
         pout_pipe_q <= 8'h00;
         oe_pipe_q <= 8'h00;
         reg_rdata <= 32'h00000000;
         route_out <= {`LTPR_NWIRE{1'b0}};
         dp_cfg_addr <= 3'h0;
         dp_shift_in <= 3'h0;
         clk_en <= 4'h0;
         clk_sel <= 8'h00;
         irq_req <= 8'h00;
         dma_req <= 8'h00;
         pin_out <= 8'h00;
         pin_oe <= 8'h00;
      end else begin
         stat_q <= stat_d;
         dpo_q <= dpo_d;
         reg_rdata <= rdata_d;
         route_out <= local_d & ~seg_q;
         dp_cfg_addr <= dp_in[2:0];
         dp_shift_in <= dp_in[5:3];
         clk_en <= clk_en_d;
         clk_sel <= cksel_q;
         irq_req <= req_raw & ~reqtype_q;
         dma_req <= req_raw & reqtype_q;
         pout_pipe_q <= pout_raw;
         oe_pipe_q <= oe_pin;
         pin_out <= (osync_q & pout_pipe_q) | (~osync_q & pout_raw);
         pin_oe <= (osync_q & oe_pipe_q) | (~osync_q & oe_pin);
      end
   end
endmodule // ltpr_top

// [shared/ltpr_regs.vh]
`ifndef LTPR_REGS_VH
`define LTPR_REGS_VH

// Routing fabric geometry
`define LTPR_NWIRE 96
`define LTPR_SEL_W 7
`define LTPR_SEL_NONE 7'h7f
`define LTPR_NSEL 56

// Register byte addresses
`define LTPR_A_CTRL 9'h000
`define LTPR_A_STATUS 9'h004
`define LTPR_A_STCAP 9'h008
`define LTPR_A_REQTYPE 9'h00c
`define LTPR_A_OSYNC 9'h010
`define LTPR_A_ISYNC 9'h014
`define LTPR_A_OEMODE 9'h018
`define LTPR_A_CKEN 9'h01c
`define LTPR_A_CKBIT 9'h020
`define LTPR_A_CKSEL 9'h024
`define LTPR_A_DPOSRC 9'h028
`define LTPR_A_SEG0 9'h02c
`define LTPR_A_SEG1 9'h030
`define LTPR_A_SEG2 9'h034
`define LTPR_A_SEL_BASE 9'h100

// Connection selector indices inside the selector table
`define LTPR_SI_CTRL 6'd0
`define LTPR_SI_DPOUT 6'd8
`define LTPR_SI_PININ 6'd14
`define LTPR_SI_STAT 6'd22
`define LTPR_SI_DPIN 6'd30
`define LTPR_SI_REQ 6'd36
`define LTPR_SI_PINOUT 6'd44
`define LTPR_SI_OE 6'd52

// Output enable grouping modes
`define LTPR_OE_ALL 2'h0
`define LTPR_OE_QUAD 2'h1
`define LTPR_OE_PAIR 2'h2
`define LTPR_OE_SINGLE 2'h3

// Datapath output source codes
`define LTPR_DPO_SO0 4'h8
`define LTPR_DPO_SO1 4'h9

// Reset values
`define LTPR_RST_CKEN 8'h0f
`define LTPR_RST_ISYNC 8'hff

`endif

// [logic/ltpr_sync.v]
`timescale 1ns/1ps
module ltpr_sync #(
   parameter W = 8
) (
   input wire clk,
   input wire arst_n,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // Two-flop chain, first stage feeds only the second
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule // ltpr_sync

// [verif/ltpr_chk.sv]
`timescale 1ns/1ps
module ltpr_chk (
   input wire clk,
   input wire arst_n,
   input wire [8:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   input wire [7:0] clk_sel,
   input wire [7:0] irq_req,
   input wire [7:0] dma_req,
   input wire [7:0] pin_oe
);
   reg [7:0] ctrl_q;
   reg [7:0] cks_q;
   reg [1:0] oem_q;
   reg [1:0] age_q;
   reg [7:0] rtp_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Shadows of written registers, age since last mode write
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= 8'h00;
         cks_q <= 8'h00;
         oem_q <= 2'h0;
         age_q <= 2'h0;
         rtp_q <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == 9'h00c) rtp_q <= reg_wdata[7:0];
         if (reg_wr && reg_addr == 9'h000) ctrl_q <= reg_wdata[7:0];
         if (reg_wr && reg_addr == 9'h024) cks_q <= reg_wdata[7:0];
         if (reg_wr && reg_addr == 9'h018) oem_q <= reg_wdata[1:0];
         age_q <= (reg_wr && reg_addr == 9'h018) ? 2'h0 : (age_q == 2'h3 ? age_q : age_q + 2'h1);
      end
   end
   chk_ctrl_readback: assert property (reg_rd && reg_addr == 9'h000 |=> reg_rdata == {24'h0, ctrl_q})
      else $error("control readback wrong");
   chk_unmapped_zero: assert property (reg_rd && reg_addr == 9'h038 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_oe_all: assert property (age_q == 2'h3 && oem_q == 2'h0 |-> pin_oe == 8'h00 || pin_oe == 8'hff)
      else $error("ganged enables differ");
   chk_oe_quad: assert property (age_q == 2'h3 && oem_q == 2'h1 |->
      (pin_oe[3:0] == 4'h0 || pin_oe[3:0] == 4'hf) && (pin_oe[7:4] == 4'h0 || pin_oe[7:4] == 4'hf))
      else $error("quad enables differ");
   chk_oe_pair: assert property (age_q == 2'h3 && oem_q == 2'h2 |->
      (pin_oe & 8'h55) == ((pin_oe >> 1) & 8'h55))
      else $error("pair enables differ");
   chk_oe_single: assert property (age_q == 2'h3 && oem_q == 2'h3 |-> pin_oe[7:4] == 4'h0)
      else $error("upper pins driven");
   chk_req_split: assert property ((irq_req & dma_req) == 8'h00 && (irq_req & $past(rtp_q)) == 8'h00 &&
      (dma_req & ~$past(rtp_q)) == 8'h00)
      else $error("request on wrong line");
   chk_cksel_copy: assert property (reg_wr && reg_addr == 9'h024 |=> ##1 clk_sel == $past(cks_q))
      else $error("clock select not copied");
endmodule // ltpr_chk

bind ltpr_top ltpr_chk u_chk (
   .clk(clk),
   .arst_n(arst_n),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .clk_sel(clk_sel),
   .irq_req(irq_req),
   .dma_req(dma_req),
   .pin_oe(pin_oe)
);

// [verif/ltpr_far.sv]
`timescale 1ns/1ps
module ltpr_far (
   input wire [7:0] pin_out,
   input wire [7:0] pin_oe,
   input wire [7:0] pad_ext,
   output wire [7:0] pin_in
);
   // Pad shows own driver when enabled, far drive when released
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & pad_ext);
endmodule // ltpr_far

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
   reg clk = 1'b0;
   reg arst_n = 1'b0;
   reg [8:0] reg_addr = 9'h000;
   reg [31:0] reg_wdata = 32'h0;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg [95:0] route_in = 96'h0;
   reg [7:0] dp_cond = 8'h00;
   reg [1:0] dp_shift_out = 2'h0;
   reg [7:0] pad_ext = 8'h00;
   wire [31:0] reg_rdata;
   wire [95:0] route_out;
   wire [2:0] dp_cfg_addr, dp_shift_in;
   wire [3:0] clk_en;
   wire [7:0] clk_sel, irq_req, dma_req, pin_in, pin_out, pin_oe;
   integer failures = 0;
   integer checks = 0;
   integer i;
   reg [31:0] rd_q;
   always #10 clk = ~clk;
   ltpr_top dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .route_in(route_in), .route_out(route_out), .dp_cond(dp_cond),
      .dp_shift_out(dp_shift_out), .dp_cfg_addr(dp_cfg_addr), .dp_shift_in(dp_shift_in), .clk_en(clk_en),
      .clk_sel(clk_sel), .irq_req(irq_req), .dma_req(dma_req), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe));
   ltpr_far far (.pin_out(pin_out), .pin_oe(pin_oe), .pad_ext(pad_ext), .pin_in(pin_in));
   // One-cycle register write
   task wr(input [8:0] a, input [31:0] d);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
   endtask
   // Read, data sampled in the following cycle
   task rd(input [8:0] a);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1 rd_q = reg_rdata;
      end
   endtask
   // Let n edges pass, then settle
   task tk(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task ck(input [31:0] g, input [31:0] e);
      begin
         checks = checks + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("ERROR %0t: got %h exp %h", $time, g, e);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d failures %0d", checks, failures);
         if (failures == 0 && checks > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   // Hang guard
   initial begin
      #400000;
      failures = failures + 1;
      report_and_stop;
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      rd(9'h01c); ck(rd_q, 32'h0f);
      rd(9'h014); ck(rd_q, 32'hff);
      wr(9'h100, 32'd5);
      wr(9'h000, 32'h01);
      tk(1); ck(route_out[5], 1);
      rd(9'h000); ck(rd_q, 32'h01);
      // Capture bit 0 from wire 10, live bit 1 from wire 11
      wr(9'h158, 32'd10);
      wr(9'h15c, 32'd11);
      wr(9'h008, 32'h01);
      @(posedge clk);
      route_in[11:10] <= 2'b11;
      @(posedge clk);
      route_in[10] <= 1'b0;
      rd(9'h004); ck(rd_q, 32'h3);
      rd(9'h004); ck(rd_q, 32'h2);
      wr(9'h004, 32'hff);
      rd(9'h004); ck(rd_q, 32'h2);
      // Datapath inputs from wires 20..25, outputs to 30,31
      for (i = 0; i < 6; i = i + 1) wr(9'h178 + 4 * i, 20 + i);
      wr(9'h028, 32'h38);
      wr(9'h120, 32'd30);
      wr(9'h124, 32'd31);
      @(posedge clk);
      route_in[25:20] <= 6'h2b;
      dp_shift_out <= 2'h1;
      dp_cond <= 8'h08;
      tk(1); ck({dp_shift_in, dp_cfg_addr}, 6'h2b);
      tk(1); ck(route_out[31:30], 2'h3);
      // Output 0 from shift-out 1, which is low
      wr(9'h028, 32'h39);
      tk(2); ck(route_out[31:30], 2'h2);
      // Request from wire 60, irq then dma
      wr(9'h190, 32'd60);
      @(posedge clk);
      route_in[60] <= 1'b1;
      tk(1); ck({irq_req, dma_req}, 16'h0100);
      wr(9'h00c, 32'h01);
      tk(1); ck({irq_req, dma_req}, 16'h0001);
      // Pin 0 data from wire 40, enable 0 from wire 41
      wr(9'h1b0, 32'd40);
      wr(9'h1d0, 32'd41);
      @(posedge clk);
      route_in[41:40] <= 2'b11;
      tk(1); ck({pin_oe, pin_out[0]}, 9'h1ff);
      wr(9'h010, 32'h01);
      @(posedge clk);
      route_in[40] <= 1'b0;
      tk(1); ck(pin_out[0], 1);
      tk(1); ck(pin_out[0], 0);
      for (i = 1; i < 4; i = i + 1) begin
         wr(9'h018, i);
         tk(2); ck(pin_oe, 32'h01030fff >> (8 * i) & 32'hff);
      end
      // Pin 1 input to wire 50, synchronised then bypassed
      wr(9'h13c, 32'd50);
      @(posedge clk);
      pad_ext[1] <= 1'b1;
      tk(2); ck(route_out[50], 0);
      tk(1); ck(route_out[50], 1);
      wr(9'h014, 32'h00);
      @(posedge clk);
      pad_ext[1] <= 1'b0;
      tk(1); ck(route_out[50], 0);
      // Cut wire 40
      wr(9'h030, 32'h100);
      @(posedge clk);
      route_in[40] <= 1'b1;
      tk(2); ck(pin_out[0], 0);
      // Block 0 clock gated by control bit 2
      wr(9'h020, 32'h2);
      wr(9'h01c, 32'h1f);
      tk(1); ck(clk_en, 4'he);
      wr(9'h000, 32'h04);
      tk(1); ck(clk_en, 4'hf);
      wr(9'h024, 32'he4);
      tk(2); ck(clk_sel, 8'he4);
      rd(9'h038); ck(rd_q, 0);
      wr(9'h1e0, 32'd5);
      rd(9'h1e0); ck(rd_q, 0);
      report_and_stop;
   end
endmodule // testbench
